// *** hw/fsr_pkg.sv ***
// Package with constants, encodings and types shared by both ends of the suspend link.
package fsr_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_NS = 100;
  localparam int NS_PER_US = 1000;
  localparam int ESUSP_MAX_US = 48;
  localparam int PSUSP_MAX_US = 40;
  localparam int RES_GAP_US = 128;
  // Longest times round down, least times round up.
  localparam int ESUSP_MAX_CYC = ESUSP_MAX_US * NS_PER_US / CLK_NS;
  localparam int PSUSP_MAX_CYC = PSUSP_MAX_US * NS_PER_US / CLK_NS;
  localparam int RES_GAP_CYC = (RES_GAP_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  // ************************************************************
  // Advertised suspend parameter word fields
  // ************************************************************
  localparam logic SUP_BIT = 1'b0;
  localparam logic [1:0] UNIT_128NS = 2'h0;
  localparam logic [1:0] UNIT_1US = 2'h1;
  localparam logic [1:0] UNIT_8US = 2'h2;
  localparam logic [1:0] UNIT_64US = 2'h3;
  localparam logic [4:0] ESUSP_CNT = 5'h05;
  localparam logic [3:0] ERES_CNT = 4'h1;
  localparam logic [4:0] PSUSP_CNT = 5'h04;
  localparam logic [3:0] PRES_CNT = 4'h1;
  localparam logic RFU_BIT = 1'b1;
  localparam logic [3:0] EFORBID = 4'hE;
  localparam logic [3:0] PFORBID = 4'hC;
  localparam logic [31:0] SUSP_WORD = {SUP_BIT, UNIT_8US, ESUSP_CNT, ERES_CNT,
    UNIT_8US, PSUSP_CNT, PRES_CNT, RFU_BIT, EFORBID, PFORBID};
  localparam logic [7:0] PARAM_BASE = 8'h2C;
  localparam logic [7:0] PARAM_BLANK = 8'hFF;

  // ************************************************************
  // Opcodes and geometry
  // ************************************************************
  localparam logic [7:0] OP_ESUSP = 8'h75;
  localparam logic [7:0] OP_ERES = 8'h7A;
  localparam logic [7:0] OP_PSUSP = 8'h85;
  localparam logic [7:0] OP_PRES = 8'h8A;
  localparam logic [7:0] OP_ERASE = 8'hD8;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam int SECT_LSB = 18;
  localparam int PAGE_LSB = 9;

  // ************************************************************
  // Host register map
  // ************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PARAM = 8'h0C;
  localparam int ST_BUSY = 0;
  localparam int ST_PEND = 1;
  localparam int ST_OK = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_ESUSP = 4;
  localparam int ST_PSUSP = 5;

  // Device sequencer states.
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ERASE = 7'b0000010,
    S_PROG = 7'b0000100,
    S_EWAIT = 7'b0001000,
    S_PWAIT = 7'b0010000,
    S_ESUSP = 7'b0100000,
    S_PSUSP = 7'b1000000
  } fsr_state_t;

  // Host issuer states.
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_REQ = 3'b010,
    H_RSP = 3'b100
  } fsr_hstate_t;

  // Latency in ns for a unit code and count: (count + 1) * unit.
  function automatic int fsr_lat_ns(input logic [1:0] unit, input logic [4:0] cnt);
    int u;
    case (unit)
      UNIT_128NS: u = 128;
      UNIT_1US: u = 1000;
      UNIT_8US: u = 8000;
      default: u = 64000;
    endcase
    return (int'(cnt) + 1) * u;
  endfunction

endpackage

// *** hw/fsr_if.sv ***
// Interface joining the host controller and the flash sequencer.
`timescale 1ns/1ns
interface fsr_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_op;
  logic [31:0] cmd_addr;
  logic rsp_valid;
  logic rsp_ok;
  logic busy;
  logic erase_susp;
  logic prog_susp;
  logic [7:0] param_addr;
  logic [7:0] param_data;

  modport dev (input cmd_valid, cmd_op, cmd_addr, param_addr,
    output cmd_ready, rsp_valid, rsp_ok, busy, erase_susp, prog_susp, param_data);
  modport host (output cmd_valid, cmd_op, cmd_addr, param_addr,
    input cmd_ready, rsp_valid, rsp_ok, busy, erase_susp, prog_susp, param_data);
endinterface

// *** hw/fsr_dev.sv ***
// Flash erase and program sequencer with suspend, resume and parameter word.
// Notes on behaviour
// - Top parameter bit zero means suspend supported.
// - Latency is (count plus one) times unit.
// - Erase suspend completes within 48 us.
// - Program suspend completes within 40 us.
// - Host waits 128 us resume to erase suspend.
// - Host waits 128 us resume to program suspend.
// - Erase suspended: no erase, sector program, read.
// - Program suspended: no erase, page read.
// - Word 45_18_83_EC, low byte at 2Ch.
// - Opcodes 75h, 7Ah, 85h, 8Ah suspend and resume.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module fsr_dev #(
  parameter logic [23:0] ERASE_CYC = 24'h001388,
  parameter logic [23:0] PROG_CYC = 24'h0007D0,
  parameter logic [23:0] ESUSP_CYC = 24'(fsr_pkg::ESUSP_MAX_CYC),
  parameter logic [23:0] PSUSP_CYC = 24'(fsr_pkg::PSUSP_MAX_CYC)
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the host.
  fsr_if.dev link,
  // User side status.
  output logic [6:0] state,
  output logic [23:0] erase_left,
  output logic [23:0] prog_left
);
  import fsr_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  fsr_state_t st_q;
  fsr_state_t st_d;
  logic [CNT_W-1:0] erase_left_q;
  logic [CNT_W-1:0] prog_left_q;
  logic [CNT_W-1:0] lat_q;
  logic [31-SECT_LSB:0] esect_q;
  logic [31-PAGE_LSB:0] ppage_q;
  logic held_q;
  logic rsp_valid_q;
  logic rsp_ok_q;
  logic [7:0] param_q;
  logic take;
  logic ok_c;
  logic same_sect;
  logic same_page;
  logic [31:0] word;

  // Advertised word, taken straight from the package constant.
  assign word = SUSP_WORD;

  assign take = link.cmd_valid && link.cmd_ready;
  assign same_sect = link.cmd_addr[31:SECT_LSB] == esect_q;
  assign same_page = link.cmd_addr[31:PAGE_LSB] == ppage_q;

  // Commands are held off while a suspend is settling, so no order is lost mid-way.
  assign link.cmd_ready = !(st_q == S_EWAIT || st_q == S_PWAIT);

  // ************************************************************
  // Command acceptance
  // ************************************************************
  // Decide whether the offered command is legal in the present state.
  always_comb begin
    ok_c = 1'b0;
    case (link.cmd_op)
      OP_ERASE: ok_c = st_q == S_IDLE;
      OP_PROG: ok_c = st_q == S_IDLE || (st_q == S_ESUSP && !same_sect);
      OP_READ: begin
        ok_c = st_q == S_IDLE || (st_q == S_ESUSP && !same_sect) ||
          (st_q == S_PSUSP && !same_page && !(held_q && same_sect));
      end
      OP_ESUSP: ok_c = st_q == S_ERASE;
      OP_PSUSP: ok_c = st_q == S_PROG;
      OP_ERES: ok_c = st_q == S_ESUSP;
      OP_PRES: ok_c = st_q == S_PSUSP;
      default: ok_c = 1'b0;
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Next state from accepted commands, countdowns and suspend latency.
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (take && ok_c && link.cmd_op == OP_ERASE) begin
          st_d = S_ERASE;
        end else if (take && ok_c && link.cmd_op == OP_PROG) begin
          st_d = S_PROG;
        end
      end
      S_ERASE: begin
        if (take && ok_c) begin
          st_d = S_EWAIT;
        end else if (erase_left_q <= CNT_ONE) begin // A suspend on the last cycle leaves zero.
          st_d = S_IDLE;
        end
      end
      S_PROG: begin
        if (take && ok_c) begin
          st_d = S_PWAIT;
        end else if (prog_left_q <= CNT_ONE) begin
          st_d = held_q ? S_ESUSP : S_IDLE;
        end
      end
      S_EWAIT: if (lat_q == '0) st_d = S_ESUSP;
      S_PWAIT: if (lat_q == '0) st_d = S_PSUSP;
      S_ESUSP: begin
        if (take && ok_c && link.cmd_op == OP_ERES) begin
          st_d = S_ERASE;
        end else if (take && ok_c && link.cmd_op == OP_PROG) begin
          st_d = S_PROG;
        end
      end
      S_PSUSP: if (take && ok_c && link.cmd_op == OP_PRES) st_d = S_PROG;
      default: st_d = S_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Suspend latency countdown; the entry is taken at the advertised limit at the latest.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= '0;
    end else if (take && ok_c && link.cmd_op == OP_ESUSP) begin
      lat_q <= ESUSP_CYC - CNT_ONE;
    end else if (take && ok_c && link.cmd_op == OP_PSUSP) begin
      lat_q <= PSUSP_CYC - CNT_ONE;
    end else if (lat_q != '0) begin
      lat_q <= lat_q - CNT_ONE;
    end
  end

  // Erase work left; it stands still while suspended so that a resume continues it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_left_q <= '0;
    end else if (st_q == S_IDLE && st_d == S_ERASE) begin
      erase_left_q <= ERASE_CYC;
    end else if (st_q == S_ERASE && erase_left_q != '0) begin
      erase_left_q <= erase_left_q - CNT_ONE;
    end
  end

  // Program work left, loaded only on a fresh start so that it runs down and survives a suspend.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_left_q <= '0;
    end else if ((st_q == S_IDLE || st_q == S_ESUSP) && st_d == S_PROG) begin
      prog_left_q <= PROG_CYC;
    end else if (st_q == S_PROG && prog_left_q != '0) begin
      prog_left_q <= prog_left_q - CNT_ONE;
    end
  end

  // Suspended erase flag, the erase sector it protects and the program page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 1'b0;
      esect_q <= '0;
      ppage_q <= '0;
    end else begin
      if (st_q == S_EWAIT && st_d == S_ESUSP) begin
        held_q <= 1'b1;
      end else if (st_q == S_ESUSP && st_d == S_ERASE) begin
        held_q <= 1'b0;
      end
      if (st_q == S_IDLE && st_d == S_ERASE) begin
        esect_q <= link.cmd_addr[31:SECT_LSB];
      end
      if ((st_q == S_IDLE || st_q == S_ESUSP) && st_d == S_PROG) begin
        ppage_q <= link.cmd_addr[31:PAGE_LSB];
      end
    end
  end

  // ************************************************************
  // Answers and parameter read
  // ************************************************************
  // One answer per taken command, one cycle after it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_ok_q <= 1'b0;
    end else begin
      rsp_valid_q <= take;
      rsp_ok_q <= take && ok_c;
    end
  end

  // Parameter bytes go out low byte first; outside the word the array reads blank.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_q <= PARAM_BLANK;
    end else begin
      case (link.param_addr - PARAM_BASE)
        8'h00: param_q <= word[7:0];
        8'h01: param_q <= word[15:8];
        8'h02: param_q <= word[23:16];
        8'h03: param_q <= word[31:24];
        default: param_q <= PARAM_BLANK;
      endcase
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_ok = rsp_ok_q;
  assign link.busy = st_q != S_IDLE && st_q != S_ESUSP && st_q != S_PSUSP;
  assign link.erase_susp = held_q;
  assign link.prog_susp = st_q == S_PSUSP;
  assign link.param_data = param_q;
  assign state = st_q;
  assign erase_left = erase_left_q;
  assign prog_left = prog_left_q;
endmodule

// *** hw/fsr_host.sv ***
// Host controller: APB registers, suspend spacing and forbidden-operation checks.
`timescale 1ns/1ns
module fsr_host (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device.
  fsr_if.host link
);
  import fsr_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  fsr_hstate_t hs_q;
  logic [7:0] op_q;
  logic [31:0] addr_q;
  logic [7:0] pofs_q;
  logic ok_q;
  logic refused_q;
  logic [31:0] prdata_q;
  logic [CNT_W-1:0] egap_q;
  logic [CNT_W-1:0] pgap_q;
  logic wr;
  logic mapped;
  logic forbid;
  logic hold;
  logic esect_hit;
  logic ppage_hit;
  logic [31:0] lsect_q;
  logic [31:0] lpage_q;

  assign wr = psel && penable && pwrite;
  assign mapped = paddr[7:0] == REG_CMD || paddr[7:0] == REG_ADDR ||
    paddr[7:0] == REG_STAT || paddr[7:0] == REG_PARAM;

  // One wait-free access phase; read data was latched in the setup cycle.
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // Software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= '0;
      addr_q <= '0;
      pofs_q <= '0;
    end else if (wr) begin
      if (paddr[7:0] == REG_CMD && hs_q == H_IDLE) op_q <= pwdata[7:0];
      if (paddr[7:0] == REG_ADDR) addr_q <= pwdata;
      if (paddr[7:0] == REG_PARAM) pofs_q <= pwdata[7:0];
    end
  end

  // Read data capture in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      case (paddr[7:0])
        REG_CMD: prdata_q <= {24'h000000, op_q};
        REG_ADDR: prdata_q <= addr_q;
        REG_STAT: begin
          prdata_q <= '0;
          prdata_q[ST_BUSY] <= link.busy;
          prdata_q[ST_PEND] <= hs_q != H_IDLE;
          prdata_q[ST_OK] <= ok_q;
          prdata_q[ST_REFUSED] <= refused_q;
          prdata_q[ST_ESUSP] <= link.erase_susp;
          prdata_q[ST_PSUSP] <= link.prog_susp;
        end
        REG_PARAM: prdata_q <= {16'h0000, link.param_data, pofs_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // ************************************************************
  // Command issuer
  // ************************************************************
  assign esect_hit = addr_q[31:SECT_LSB] == lsect_q[31:SECT_LSB];
  assign ppage_hit = addr_q[31:PAGE_LSB] == lpage_q[31:PAGE_LSB];

  // Operations the host must not start while something is suspended.
  always_comb begin
    forbid = 1'b0;
    case (op_q)
      OP_ERASE: forbid = link.erase_susp || link.prog_susp;
      OP_PROG: forbid = link.erase_susp && esect_hit;
      OP_READ: begin
        forbid = (link.erase_susp && esect_hit) ||
          (link.prog_susp && ppage_hit);
      end
      default: forbid = 1'b0;
    endcase
  end

  // A suspend waits out the resume spacing instead of being dropped.
  assign hold = (op_q == OP_ESUSP && egap_q != '0) ||
    (op_q == OP_PSUSP && pgap_q != '0);
  // A forbidden order is never offered, not even in the cycle that refuses it.
  assign link.cmd_valid = hs_q == H_REQ && !hold && !forbid;
  assign link.cmd_op = op_q;
  assign link.cmd_addr = addr_q;
  assign link.param_addr = pofs_q;

  // Issuer state and result flags; a new command clears the old result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= H_IDLE;
      ok_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      case (hs_q)
        H_IDLE: begin
          if (wr && paddr[7:0] == REG_CMD) begin
            hs_q <= H_REQ;
            ok_q <= 1'b0;
            refused_q <= 1'b0;
          end
        end
        H_REQ: begin
          if (forbid) begin
            hs_q <= H_IDLE;
            refused_q <= 1'b1;
          end else if (link.cmd_valid && link.cmd_ready) begin
            hs_q <= H_RSP;
          end
        end
        H_RSP: begin
          if (link.rsp_valid) begin
            hs_q <= H_IDLE;
            ok_q <= link.rsp_ok;
          end
        end
        default: hs_q <= H_IDLE;
      endcase
    end
  end

  // Resume spacing timers and last erase and program addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      egap_q <= '0;
      pgap_q <= '0;
      lsect_q <= '0;
      lpage_q <= '0;
    end else begin
      if (hs_q == H_RSP && link.rsp_valid && link.rsp_ok && op_q == OP_ERES) begin
        egap_q <= CNT_W'(RES_GAP_CYC);
      end else if (egap_q != '0) begin
        egap_q <= egap_q - CNT_ONE;
      end
      if (hs_q == H_RSP && link.rsp_valid && link.rsp_ok && op_q == OP_PRES) begin
        pgap_q <= CNT_W'(RES_GAP_CYC);
      end else if (pgap_q != '0) begin
        pgap_q <= pgap_q - CNT_ONE;
      end
      if (hs_q == H_RSP && link.rsp_valid && link.rsp_ok && op_q == OP_ERASE) begin
        lsect_q <= addr_q;
      end
      if (hs_q == H_RSP && link.rsp_valid && link.rsp_ok && op_q == OP_PROG) begin
        lpage_q <= addr_q;
      end
    end
  end
endmodule

// *** testbench/fsr_link_asserts.sv ***
// Concurrent checks on the link between the host controller and the sequencer.
`timescale 1ns/1ns
module fsr_link_asserts
  import fsr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Host to device.
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [31:0] cmd_addr,
  input wire logic [7:0] param_addr,
  // Device to host.
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic busy,
  input wire logic erase_susp,
  input wire logic prog_susp,
  input wire logic [7:0] param_data
);
  localparam int E_LAT = 480;
  localparam int P_LAT = 400;
  logic take;
  logic [7:0] op_q;
  logic [11:0] egap_q;
  logic [11:0] pgap_q;
  logic [7:0] byte_exp;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The word is spelled out here so the check does not lean on the design's constant.
  assign take = cmd_valid && cmd_ready;
  assign byte_exp = 8'(32'h451883EC >> {param_addr[1:0], 3'h0});

  // Opcode of the last take, to tell which command an answer belongs to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
    end else if (take) begin
      op_q <= cmd_op;
    end
  end

  // Cycles since the last accepted resume; saturation keeps an old resume harmless.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      egap_q <= 12'hFFF;
      pgap_q <= 12'hFFF;
    end else begin
      if (rsp_valid && rsp_ok && op_q == OP_ERES) begin
        egap_q <= 12'h000;
      end else if (egap_q != 12'hFFF) begin
        egap_q <= egap_q + 12'h001;
      end
      if (rsp_valid && rsp_ok && op_q == OP_PRES) begin
        pgap_q <= 12'h000;
      end else if (pgap_q != 12'hFFF) begin
        pgap_q <= pgap_q + 12'h001;
      end
    end
  end

  // ********
  // Assertions
  // ********
  a_rsp_after_take: assert property (take |=> rsp_valid)
    else $error("no answer one cycle after a take");
  a_rsp_needs_take: assert property (rsp_valid |-> $past(take))
    else $error("answer without a take");
  a_erase_susp_lat: assert property (
    take && cmd_op == OP_ESUSP ##1 rsp_ok |-> ##[1:E_LAT] erase_susp)
    else $error("erase suspend too slow");
  a_prog_susp_lat: assert property (
    take && cmd_op == OP_PSUSP ##1 rsp_ok |-> ##[1:P_LAT] prog_susp)
    else $error("program suspend too slow");
  a_erase_gap: assert property (take && cmd_op == OP_ESUSP |-> egap_q >= 12'h4FE)
    else $error("erase suspend too soon after resume");
  a_prog_gap: assert property (take && cmd_op == OP_PSUSP |-> pgap_q >= 12'h4FE)
    else $error("program suspend too soon after resume");
  a_no_nested_erase: assert property (
    take && cmd_op == OP_ERASE |-> !erase_susp && !prog_susp)
    else $error("erase sent while suspended");
  a_erase_resume: assert property (
    take && cmd_op == OP_ERES && erase_susp && !busy && !prog_susp
    |=> rsp_ok && busy && !erase_susp)
    else $error("erase resume not honoured");
  a_prog_resume: assert property (
    take && cmd_op == OP_PRES && prog_susp
    |=> rsp_ok && busy && !prog_susp)
    else $error("program resume not honoured");
  a_susp_held: assert property (
    erase_susp && !(take && cmd_op == OP_ERES) |=> erase_susp)
    else $error("held erase lost without resume");
  a_param_word: assert property (
    param_addr[7:2] == 6'h0B |=> param_data == $past(byte_exp))
    else $error("parameter byte wrong");
  a_param_blank: assert property (param_addr[7:2] != 6'h0B |=> param_data == 8'hFF)
    else $error("blank parameter byte wrong");

  c_erase_susp: cover property ($rose(erase_susp));
  c_prog_susp: cover property ($rose(prog_susp));
  c_refused: cover property (rsp_valid && !rsp_ok);
endmodule

// *** testbench/tb_top.sv ***
// Bench driving the host over APB and a second sequencer directly on its link.
`timescale 1ns/1ns
module tb_top;
  import fsr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] st2;
  logic [6:0] st1;
  logic [23:0] el;
  logic [23:0] pl;
  logic [23:0] el2;
  logic [7:0] pb [6] = '{8'hFF, 8'hEC, 8'h83, 8'h18, 8'h45, 8'hFF};
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  fsr_if lk();
  fsr_if lk2();

  // Clock and a cycle count for measuring gaps.
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  fsr_dev i_fsr_dev (.pclk(pclk), .presetn(presetn), .link(lk), .state(st1),
    .erase_left(el), .prog_left(pl));
  fsr_host i_fsr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lk));
  // Second sequencer, driven raw so that host faults can be committed on purpose.
  fsr_dev i_fsr_dev_b (.pclk(pclk), .presetn(presetn), .link(lk2), .state(st2),
    .erase_left(el2), .prog_left());
  fsr_link_asserts i_fsr_link_asserts (.pclk(pclk), .presetn(presetn),
    .cmd_valid(lk.cmd_valid), .cmd_op(lk.cmd_op), .cmd_addr(lk.cmd_addr),
    .param_addr(lk.param_addr), .cmd_ready(lk.cmd_ready), .rsp_valid(lk.rsp_valid),
    .rsp_ok(lk.rsp_ok), .busy(lk.busy), .erase_susp(lk.erase_susp),
    .prog_susp(lk.prog_susp), .param_data(lk.param_data));

  // ********
  // Tasks
  // ********
  task automatic conclude();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic st(input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, REG_STAT, 32'h00000000, d, e);
    chk("status", exp, d);
  endtask

  // Issue a command through the host, wait until it is no longer pending, judge status.
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [31:0] exp,
      output int t);
    logic [31:0] d;
    logic e;
    apb(1'b1, REG_ADDR, a, d, e);
    apb(1'b1, REG_CMD, {24'h000000, op}, d, e);
    d = 32'h00000002;
    while (d[ST_PEND]) apb(1'b0, REG_STAT, 32'h00000000, d, e);
    t = cyc;
    chk("cmd_status", exp, d);
  endtask

  // Raw command on the second link; valid is held until the take.
  task automatic lnk(input logic [7:0] op, input logic [31:0] a, input logic ok);
    @(posedge pclk);
    lk2.cmd_valid <= 1'b1;
    lk2.cmd_op <= op;
    lk2.cmd_addr <= a;
    @(posedge pclk);
    while (lk2.cmd_ready !== 1'b1) @(posedge pclk);
    lk2.cmd_valid <= 1'b0;
    @(posedge pclk);
    chk("link_rsp", {30'h0, 1'b1, ok}, {30'h0, lk2.rsp_valid, lk2.rsp_ok});
  endtask

  // The span covers all scenarios with a wide margin.
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    conclude();
  end

  // ********
  // Scenarios
  // ********
  // Status after reset, an unmapped offset and the advertised parameter bytes.
  task automatic scn_regs();
    logic [31:0] d;
    logic e;
    st(32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000, d, e);
    chk("unmapped", 32'h00000001, {d[30:0], e});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, REG_PARAM, 32'h2B + 32'(i), d, e);
      apb(1'b0, REG_PARAM, 32'h00000000, d, e);
      chk("param", {16'h0000, pb[i], 8'h2B + 8'(i)}, d);
    end
  endtask

  // A faulty host on the second link: forbidden work while an erase is held.
  task automatic scn_raw_link();
    logic [23:0] v;
    lnk(OP_ERASE, 32'h00000000, 1'b1);
    lnk(OP_PRES, 32'h00000000, 1'b0);
    lnk(OP_ESUSP, 32'h00000000, 1'b1);
    lnk(OP_ERASE, 32'h00080000, 1'b0);
    lnk(OP_PROG, 32'h00000100, 1'b0);
    lnk(OP_READ, 32'h0003FFFF, 1'b0);
    chk("state", 32'h00000020, {25'h0, st2});
    v = el2;
    repeat (20) @(posedge pclk);
    chk("erase_frozen", {8'h00, v}, {8'h00, el2});
    lnk(OP_ERES, 32'h00000000, 1'b1);
    repeat (4) @(posedge pclk);
    chk("erase_runs", 32'h1, {31'h0, el2 < v});
  endtask

  // Erase, suspend and nested program through the host.
  task automatic scn_nested();
    int t0;
    cmd(OP_ERASE, 32'h00000000, 32'h05, t0);
    cmd(OP_ESUSP, 32'h00000000, 32'h05, t0);
    repeat (490) @(posedge pclk);
    st(32'h00000014);
    cmd(OP_ERASE, 32'h00080000, 32'h18, t0);
    cmd(OP_PROG, 32'h00000100, 32'h18, t0);
    cmd(OP_READ, 32'h0003FFFF, 32'h18, t0);
    cmd(OP_READ, 32'h00040000, 32'h14, t0);
    cmd(OP_PROG, 32'h00040000, 32'h15, t0);
    cmd(OP_PSUSP, 32'h00000000, 32'h15, t0);
    repeat (410) @(posedge pclk);
    st(32'h00000034);
    cmd(OP_READ, 32'h000401FF, 32'h38, t0);
    cmd(OP_ERASE, 32'h00080000, 32'h38, t0);
    cmd(OP_READ, 32'h00040200, 32'h34, t0);
  endtask

  // Program resume spacing, then the nested program runs to its end.
  task automatic scn_prog_gap();
    int t0;
    int t1;
    cmd(OP_PRES, 32'h00000000, 32'h15, t0);
    cmd(OP_PSUSP, 32'h00000000, 32'h15, t1);
    chk("prog_gap", 32'h1, {31'h0, (t1 - t0) inside {[1277:1295]}});
    repeat (410) @(posedge pclk);
    cmd(OP_PRES, 32'h00000000, 32'h15, t0);
    repeat (800) @(posedge pclk);
    st(32'h00000014);
  endtask

  // Erase resume spacing, then the erase runs to its end.
  task automatic scn_erase_gap();
    int t0;
    int t1;
    cmd(OP_ERES, 32'h00000000, 32'h05, t0);
    cmd(OP_ESUSP, 32'h00000000, 32'h05, t1);
    chk("erase_gap", 32'h1, {31'h0, (t1 - t0) inside {[1277:1295]}});
    repeat (490) @(posedge pclk);
    st(32'h00000014);
    cmd(OP_ERES, 32'h00000000, 32'h05, t0);
    repeat (5000) @(posedge pclk);
    st(32'h00000004);
    chk("state_end", 32'h00000001, {25'h0, st1});
    chk("erase_left", 32'h00000000, {8'h00, el});
    chk("prog_left", 32'h00000000, {8'h00, pl});
  endtask

  // Reset for eight cycles, then every scenario in turn.
  initial begin
    lk2.cmd_valid = 1'b0;
    lk2.cmd_op = 8'h00;
    lk2.cmd_addr = 32'h00000000;
    lk2.param_addr = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    scn_regs();
    scn_raw_link();
    scn_nested();
    scn_prog_gap();
    scn_erase_gap();
    conclude();
  end
endmodule
